// [bfr_defs.vh]
`ifndef BFR_DEFS_VH
`define BFR_DEFS_VH

// Register indices, byte address is four times the index
`define BFR_IDX_CTRL       4'h0
`define BFR_IDX_STATUS     4'h1
`define BFR_IDX_SP         4'h2
`define BFR_IDX_SR         4'h3
`define BFR_IDX_PC         4'h4
`define BFR_IDX_STAGE_B    4'h5
`define BFR_IDX_STAGE_C    4'h6
`define BFR_IDX_FRAME_BASE 4'h7
`define BFR_IDX_VERSION    4'h8
`define BFR_IDX_FSW        4'ha

// Control and status bits
`define BFR_CTRL_START     0
`define BFR_ST_BUSY        0
`define BFR_ST_HALTED      1
`define BFR_ST_CODE_LO     2
`define BFR_ST_RERUN_B     4
`define BFR_ST_RERUN_C     5
`define BFR_ST_OPT_B       6
`define BFR_ST_OPT_C       7
`define BFR_ST_RERUN_DATA  8

// Fault status word fields
`define BFR_FSW_FC         15
`define BFR_FSW_FB         14
`define BFR_FSW_RC         13
`define BFR_FSW_RB         12
`define BFR_FSW_DF         8
`define BFR_FSW_RM         7
`define BFR_FSW_RW         6
`define BFR_FSW_SIZE_LO    4
`define BFR_FSW_SPACE_LO   0
`define BFR_FSW_RESET      16'h0000
`define BFR_FSW_SW_MASK    16'h3100

// Stack frame offsets in bytes
`define BFR_OFF_SR         8'h00
`define BFR_OFF_PC_HI      8'h02
`define BFR_OFF_PC_LO      8'h04
`define BFR_OFF_FMT        8'h06
`define BFR_OFF_FSW        8'h0a
`define BFR_OFF_STB_HI     8'h24
`define BFR_OFF_STB_LO     8'h26
`define BFR_OFF_VER        8'h36
`define BFR_CP_BYTES       8'd20

// Frame format codes
`define BFR_FMT_CP         4'h9
`define BFR_FMT_SHORT      4'ha
`define BFR_FMT_LONG       4'hb

// Last load step of each frame kind
`define BFR_LAST_CP        4'h9
`define BFR_LAST_SHORT     4'h3
`define BFR_LAST_LONG      4'h5

// Pipe stage address distances
`define BFR_PC_TO_B        32'h0000_0004
`define BFR_PC_TO_C        32'h0000_0002
`define BFR_B_TO_C         32'h0000_0002

// Status register supervisor bit and program spaces
`define BFR_SR_SUPER       13
`define BFR_SPACE_PROG_SUP 3'h6
`define BFR_SPACE_PROG_USR 3'h2

// Exception codes
`define BFR_EXC_NONE       2'h0
`define BFR_EXC_BUS        2'h1
`define BFR_EXC_ADDR       2'h2
`define BFR_EXC_FMT        2'h3

`endif

// [bfr_frame_restore.v]
// Operation
// - Coprocessor frame return reloads status, PC, internal words; stack pointer grows 20.
// - After coprocessor frame restore, read the coprocessor response register.
// - Bus-fault frame return first checks the stacked format code.
// - Long frame compares version nibble 15-12 at offset 0x36 with own.
// - Validation reads both start and end of the frame; coprocessor frames here get no end read, only start and format.
// - Bad format or version gives format error; failed read gives bus error.
// - Valid frame is loaded, stack released, processing resumes.
// - Bus fault input during frame load halts the device.
// - Validation errors build the new frame below; faulty frame untouched.
// - Data bus error exception taken right after the faulting cycle.
// - Faulted prefetch raises no exception unless the word is used.
// - Short frame: stage B at PC plus four, stage C PC plus two.
// - Long frame: stage B from offset 0x24, stage C two below.
// - Address errors only on instruction fetch, taken before cycle starts.
// - Fault status word sits at offset 0xA of both bus-fault frames.
// - Address error: fault bits clear, rerun both or only stage C.
// - Stage fault bit set when an invalid faulted stage is used.
// - Rerun bit set on stage prefetch fault, with or without its fault bit.
// - Return reruns if rerun and fault set; optional if rerun only; else accept.
// - Rerun prefetch uses program space of stacked status privilege.
// - Data fault bit set on data fault; on reload it reruns the access.
// - Low half records locked, direction, size, space; 11-9 and 3 reserved.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
`include "bfr_defs.vh"

module bfr_frame_restore #(
  parameter [3:0] CORE_VERSION = 4'h0,
  parameter [7:0] SHORT_BYTES  = 8'd32,
  parameter [7:0] LONG_BYTES   = 8'd92
) (
  input  wire        I_CLOCK,
  input  wire        I_SYS_RST,
  input  wire        I_WB_CYC,
  input  wire        I_WB_STB,
  input  wire        I_WB_WE,
  input  wire [5:0]  I_WB_ADR,
  input  wire [31:0] I_WB_DAT,
  input  wire [3:0]  I_WB_SEL,
  output reg  [31:0] O_WB_DAT,
  output reg         O_WB_ACK,
  output reg         O_MEM_REQ,
  output reg  [31:0] O_MEM_ADDR,
  input  wire        I_MEM_ACK,
  input  wire [15:0] I_MEM_RDATA,
  input  wire        I_BUS_FAULT_INPUT,
  input  wire        I_DATA_FAULT,
  input  wire        I_DATA_LOCKED,
  input  wire        I_DATA_READ,
  input  wire [1:0]  I_DATA_SIZE,
  input  wire [2:0]  I_DATA_SPACE,
  input  wire        I_PREF_ERR_B,
  input  wire        I_PREF_ERR_C,
  input  wire        I_PREF_FILL_B,
  input  wire        I_PREF_FILL_C,
  input  wire        I_USE_B,
  input  wire        I_USE_C,
  input  wire        I_PREF_REQ,
  input  wire        I_PREF_ADDR_ERR,
  input  wire        I_PIPE_BOTH,
  output reg         O_PREF_START,
  output reg         O_EXC_TAKE,
  output reg  [1:0]  O_EXC_CODE,
  output reg         O_HALTED,
  output reg         O_RET_DONE,
  output reg         O_CP_RESP_RD,
  output reg         O_RERUN_B,
  output reg         O_RERUN_C,
  output reg         O_OPT_PREF_B,
  output reg         O_OPT_PREF_C,
  output reg         O_RERUN_DATA,
  output reg  [2:0]  O_PREF_SPACE
);

  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_VSTART = 3'h1;
  localparam [2:0] S_VFMT   = 3'h2;
  localparam [2:0] S_VVER   = 3'h3;
  localparam [2:0] S_VEND   = 3'h4;
  localparam [2:0] S_LOAD   = 3'h5;
  localparam [2:0] S_FIN    = 3'h6;
  localparam [2:0] S_HALT   = 3'h7;

  reg [2:0]  state_reg;
  reg [3:0]  fmt_reg;
  reg [3:0]  idx_reg;
  reg [31:0] sp_reg;
  reg [15:0] sr_reg;
  reg [31:0] pc_reg;
  reg [31:0] stage_b_reg;
  reg [31:0] stage_c_reg;
  reg [31:0] frame_base_reg;
  reg [15:0] fsw_reg;
  reg        inv_b_reg;
  reg        inv_c_reg;
  reg [15:0] cp_word [0:9];
  reg [31:0] rd_data;

  wire [3:0] wb_idx = I_WB_ADR[5:2];
  wire       wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire       wb_wr  = wb_req & I_WB_WE;
  wire       idle   = (state_reg == S_IDLE);
  wire       use_b  = I_USE_B & inv_b_reg;
  wire       use_c  = I_USE_C & inv_c_reg;
  wire       addr_err = I_PREF_REQ & I_PREF_ADDR_ERR;
  wire       mem_done = O_MEM_REQ & (I_MEM_ACK | I_BUS_FAULT_INPUT);

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer k;
    begin
      merge = old_v;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k])
          merge[8*k +: 8] = new_v[8*k +: 8];
    end
  endfunction

  function [7:0] frame_bytes;
    input [3:0] fmt;
    begin
      if (fmt == `BFR_FMT_CP)
        frame_bytes = `BFR_CP_BYTES;
      else if (fmt == `BFR_FMT_SHORT)
        frame_bytes = SHORT_BYTES;
      else
        frame_bytes = LONG_BYTES;
    end
  endfunction

  function [3:0] last_step;
    input [3:0] fmt;
    begin
      if (fmt == `BFR_FMT_CP)
        last_step = `BFR_LAST_CP;
      else if (fmt == `BFR_FMT_SHORT)
        last_step = `BFR_LAST_SHORT;
      else
        last_step = `BFR_LAST_LONG;
    end
  endfunction

  // Offset of each load step within the frame
  function [7:0] load_off;
    input [3:0] fmt;
    input [3:0] i;
    begin
      if (fmt == `BFR_FMT_CP)
        load_off = {3'h0, i, 1'b0};
      else
        case (i)
          4'h0:    load_off = `BFR_OFF_SR;
          4'h1:    load_off = `BFR_OFF_PC_HI;
          4'h2:    load_off = `BFR_OFF_PC_LO;
          4'h3:    load_off = `BFR_OFF_FSW;
          4'h4:    load_off = `BFR_OFF_STB_HI;
          default: load_off = `BFR_OFF_STB_LO;
        endcase
    end
  endfunction

  task start_rd;
    input [2:0] st;
    input [7:0] off;
    begin
      state_reg  <= st;
      O_MEM_REQ  <= 1'b1;
      O_MEM_ADDR <= sp_reg + {24'h0, off};
    end
  endtask

  // Exception frame goes below the untouched frame
  task raise;
    input [1:0] code;
    begin
      O_EXC_TAKE     <= 1'b1;
      O_EXC_CODE     <= code;
      frame_base_reg <= sp_reg;
      state_reg      <= S_IDLE;
    end
  endtask

  always @*
  begin
    rd_data = 32'h0000_0000;
    if (wb_idx == `BFR_IDX_STATUS)
    begin
      rd_data[`BFR_ST_BUSY]       = ~idle;
      rd_data[`BFR_ST_HALTED]     = O_HALTED;
      rd_data[`BFR_ST_CODE_LO +: 2] = O_EXC_CODE;
      rd_data[`BFR_ST_RERUN_B]    = O_RERUN_B;
      rd_data[`BFR_ST_RERUN_C]    = O_RERUN_C;
      rd_data[`BFR_ST_OPT_B]      = O_OPT_PREF_B;
      rd_data[`BFR_ST_OPT_C]      = O_OPT_PREF_C;
      rd_data[`BFR_ST_RERUN_DATA] = O_RERUN_DATA;
    end
    else if (wb_idx == `BFR_IDX_SP)
      rd_data = sp_reg;
    else if (wb_idx == `BFR_IDX_SR)
      rd_data = {16'h0000, sr_reg};
    else if (wb_idx == `BFR_IDX_PC)
      rd_data = pc_reg;
    else if (wb_idx == `BFR_IDX_STAGE_B)
      rd_data = stage_b_reg;
    else if (wb_idx == `BFR_IDX_STAGE_C)
      rd_data = stage_c_reg;
    else if (wb_idx == `BFR_IDX_FRAME_BASE)
      rd_data = frame_base_reg;
    else if (wb_idx == `BFR_IDX_VERSION)
      rd_data = {28'h0000000, CORE_VERSION};
    else if (wb_idx == `BFR_IDX_FSW)
      rd_data = {16'h0000, fsw_reg};
  end

  always @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      state_reg      <= S_IDLE;
      fmt_reg        <= 4'h0;
      idx_reg        <= 4'h0;
      sp_reg         <= 32'h0000_0000;
      sr_reg         <= 16'h0000;
      pc_reg         <= 32'h0000_0000;
      stage_b_reg    <= 32'h0000_0000;
      stage_c_reg    <= 32'h0000_0000;
      frame_base_reg <= 32'h0000_0000;
      fsw_reg        <= `BFR_FSW_RESET;
      inv_b_reg      <= 1'b0;
      inv_c_reg      <= 1'b0;
      O_WB_DAT       <= 32'h0000_0000;
      O_WB_ACK       <= 1'b0;
      O_MEM_REQ      <= 1'b0;
      O_MEM_ADDR     <= 32'h0000_0000;
      O_PREF_START   <= 1'b0;
      O_EXC_TAKE     <= 1'b0;
      O_EXC_CODE     <= `BFR_EXC_NONE;
      O_HALTED       <= 1'b0;
      O_RET_DONE     <= 1'b0;
      O_CP_RESP_RD   <= 1'b0;
      O_RERUN_B      <= 1'b0;
      O_RERUN_C      <= 1'b0;
      O_OPT_PREF_B   <= 1'b0;
      O_OPT_PREF_C   <= 1'b0;
      O_RERUN_DATA   <= 1'b0;
      O_PREF_SPACE   <= `BFR_SPACE_PROG_SUP;
    end
    else
    begin
      O_WB_ACK     <= wb_req;
      O_WB_DAT     <= rd_data;
      O_EXC_TAKE   <= 1'b0;
      O_RET_DONE   <= 1'b0;
      O_CP_RESP_RD <= 1'b0;
      // Faulted fetch never starts on the bus
      O_PREF_START <= I_PREF_REQ & ~I_PREF_ADDR_ERR;

      // Stage valid tracking, a fault beats a fill
      if (I_PREF_FILL_B)
        inv_b_reg <= 1'b0;
      if (I_PREF_ERR_B)
        inv_b_reg <= 1'b1;
      if (I_PREF_FILL_C)
        inv_c_reg <= 1'b0;
      if (I_PREF_ERR_C)
        inv_c_reg <= 1'b1;

      if (wb_wr && idle)
      begin
        if (wb_idx == `BFR_IDX_SP)
          sp_reg <= merge(sp_reg, I_WB_DAT, I_WB_SEL);
        else if (wb_idx == `BFR_IDX_FSW)
          fsw_reg <= (fsw_reg & ~`BFR_FSW_SW_MASK)
                   | (I_WB_DAT[15:0] & `BFR_FSW_SW_MASK);
        else if (wb_idx == `BFR_IDX_CTRL && I_WB_SEL[0] && I_WB_DAT[`BFR_CTRL_START])
        begin
          O_RERUN_B    <= 1'b0;
          O_RERUN_C    <= 1'b0;
          O_OPT_PREF_B <= 1'b0;
          O_OPT_PREF_C <= 1'b0;
          O_RERUN_DATA <= 1'b0;
          start_rd(S_VSTART, `BFR_OFF_SR);
        end
      end

      case (state_reg)
        S_IDLE:
        begin
          // Unused prefetch faults only mark the stage
          if (I_DATA_FAULT || use_b || use_c || addr_err)
          begin
            O_EXC_TAKE     <= 1'b1;
            O_EXC_CODE     <= addr_err ? `BFR_EXC_ADDR : `BFR_EXC_BUS;
            frame_base_reg <= sp_reg;
            fsw_reg        <= `BFR_FSW_RESET;
            if (addr_err)
            begin
              fsw_reg[`BFR_FSW_RC] <= 1'b1;
              fsw_reg[`BFR_FSW_RB] <= I_PIPE_BOTH;
            end
            else
            begin
              fsw_reg[`BFR_FSW_FC] <= use_c;
              fsw_reg[`BFR_FSW_FB] <= use_b;
              fsw_reg[`BFR_FSW_RC] <= inv_c_reg | I_PREF_ERR_C;
              fsw_reg[`BFR_FSW_RB] <= inv_b_reg | I_PREF_ERR_B;
            end
            if (I_DATA_FAULT)
            begin
              fsw_reg[`BFR_FSW_DF] <= 1'b1;
              fsw_reg[`BFR_FSW_RM] <= I_DATA_LOCKED;
              fsw_reg[`BFR_FSW_RW] <= I_DATA_READ;
              fsw_reg[`BFR_FSW_SIZE_LO +: 2]  <= I_DATA_SIZE;
              fsw_reg[`BFR_FSW_SPACE_LO +: 3] <= I_DATA_SPACE;
            end
          end
        end
        S_VSTART, S_VFMT, S_VVER, S_VEND:
        begin
          if (mem_done)
          begin
            O_MEM_REQ <= 1'b0;
            if (I_BUS_FAULT_INPUT)
              raise(`BFR_EXC_BUS);
            else if (state_reg == S_VSTART)
              start_rd(S_VFMT, `BFR_OFF_FMT);
            else if (state_reg == S_VFMT)
            begin
              fmt_reg <= I_MEM_RDATA[15:12];
              idx_reg <= 4'h0;
              if (I_MEM_RDATA[15:12] == `BFR_FMT_CP)
                start_rd(S_LOAD, load_off(`BFR_FMT_CP, 4'h0));
              else if (I_MEM_RDATA[15:12] == `BFR_FMT_SHORT)
                start_rd(S_VEND, SHORT_BYTES - 8'd2);
              else if (I_MEM_RDATA[15:12] == `BFR_FMT_LONG)
                start_rd(S_VVER, `BFR_OFF_VER);
              else
                raise(`BFR_EXC_FMT);
            end
            else if (state_reg == S_VVER)
            begin
              if (I_MEM_RDATA[15:12] != CORE_VERSION)
                raise(`BFR_EXC_FMT);
              else
                start_rd(S_VEND, LONG_BYTES - 8'd2);
            end
            else
              start_rd(S_LOAD, load_off(fmt_reg, 4'h0));
          end
        end
        S_LOAD:
        begin
          if (mem_done)
          begin
            O_MEM_REQ <= 1'b0;
            if (I_BUS_FAULT_INPUT)
            begin
              state_reg <= S_HALT;
              O_HALTED  <= 1'b1;
            end
            else
            begin
              if (fmt_reg == `BFR_FMT_CP)
                cp_word[idx_reg] <= I_MEM_RDATA;
              case (load_off(fmt_reg, idx_reg))
                `BFR_OFF_SR:     sr_reg <= I_MEM_RDATA;
                `BFR_OFF_PC_HI:  pc_reg[31:16] <= I_MEM_RDATA;
                `BFR_OFF_PC_LO:  pc_reg[15:0] <= I_MEM_RDATA;
                `BFR_OFF_FSW:    fsw_reg <= (fmt_reg == `BFR_FMT_CP) ? fsw_reg : I_MEM_RDATA;
                `BFR_OFF_STB_HI: stage_b_reg[31:16] <= I_MEM_RDATA;
                `BFR_OFF_STB_LO: stage_b_reg[15:0] <= I_MEM_RDATA;
                default:         idx_reg <= idx_reg;
              endcase
              if (idx_reg == last_step(fmt_reg))
                state_reg <= S_FIN;
              else
              begin
                idx_reg <= idx_reg + 4'h1;
                start_rd(S_LOAD, load_off(fmt_reg, idx_reg + 4'h1));
              end
            end
          end
        end
        S_FIN:
        begin
          sp_reg     <= sp_reg + {24'h0, frame_bytes(fmt_reg)};
          O_RET_DONE <= 1'b1;
          state_reg  <= S_IDLE;
          if (fmt_reg == `BFR_FMT_CP)
            O_CP_RESP_RD <= 1'b1;
          else
          begin
            if (fmt_reg == `BFR_FMT_SHORT)
            begin
              stage_b_reg <= pc_reg + `BFR_PC_TO_B;
              stage_c_reg <= pc_reg + `BFR_PC_TO_C;
            end
            else
              stage_c_reg <= stage_b_reg - `BFR_B_TO_C;
            O_RERUN_B    <= fsw_reg[`BFR_FSW_RB] & fsw_reg[`BFR_FSW_FB];
            O_RERUN_C    <= fsw_reg[`BFR_FSW_RC] & fsw_reg[`BFR_FSW_FC];
            O_OPT_PREF_B <= fsw_reg[`BFR_FSW_RB] & ~fsw_reg[`BFR_FSW_FB];
            O_OPT_PREF_C <= fsw_reg[`BFR_FSW_RC] & ~fsw_reg[`BFR_FSW_FC];
            O_RERUN_DATA <= fsw_reg[`BFR_FSW_DF];
            O_PREF_SPACE <= sr_reg[`BFR_SR_SUPER] ? `BFR_SPACE_PROG_SUP
                                                  : `BFR_SPACE_PROG_USR;
          end
        end
        default:
          state_reg <= S_HALT;
      endcase
    end
  end

endmodule

// [bfr_frame_restore_sva.sv]
`timescale 1ns/100ps
module bfr_frame_restore_sva (
  input wire        I_CLOCK,
  input wire        I_SYS_RST,
  input wire        I_WB_CYC,
  input wire        I_WB_STB,
  input wire        O_WB_ACK,
  input wire        O_MEM_REQ,
  input wire [31:0] O_MEM_ADDR,
  input wire        I_MEM_ACK,
  input wire        I_BUS_FAULT_INPUT,
  input wire        I_DATA_FAULT,
  input wire        I_PREF_REQ,
  input wire        I_PREF_ADDR_ERR,
  input wire        O_PREF_START,
  input wire        O_EXC_TAKE,
  input wire [1:0]  O_EXC_CODE,
  input wire        O_HALTED,
  input wire        O_RET_DONE,
  input wire        O_CP_RESP_RD,
  input wire        O_RERUN_B,
  input wire        O_OPT_PREF_B
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST);

  AST_ACK: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("bus ack late");
  AST_ACK_ONE: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("bus ack longer than one cycle");
  AST_DATA_EXC: assert property (I_DATA_FAULT && !I_PREF_REQ && !O_MEM_REQ && !O_HALTED
    && !$past(I_MEM_ACK)
    |=> O_EXC_TAKE && O_EXC_CODE == 2'h1) else $error("data fault exception missing");
  AST_ADDR_EXC: assert property (I_PREF_REQ && I_PREF_ADDR_ERR && !O_MEM_REQ && !O_HALTED
    && !$past(I_MEM_ACK)
    |=> O_EXC_TAKE && O_EXC_CODE == 2'h2 && !O_PREF_START) else $error("address error wrong");
  AST_PREF_GO: assert property (I_PREF_REQ && !I_PREF_ADDR_ERR |=> O_PREF_START)
    else $error("fetch not started");
  AST_HALT_CAUSE: assert property ($rose(O_HALTED) |-> $past(I_BUS_FAULT_INPUT))
    else $error("halt without bus fault");
  AST_HALT_STICK: assert property (O_HALTED |=> O_HALTED && !O_RET_DONE)
    else $error("halt released");
  AST_MEM_HOLD: assert property (O_MEM_REQ && !I_MEM_ACK && !I_BUS_FAULT_INPUT
    |=> O_MEM_REQ && $stable(O_MEM_ADDR)) else $error("stack read dropped");
  AST_MEM_GAP: assert property (O_MEM_REQ && I_MEM_ACK |=> !O_MEM_REQ || $changed(O_MEM_ADDR))
    else $error("stack read not advanced");
  AST_CP_RESP: assert property (O_CP_RESP_RD |-> O_RET_DONE)
    else $error("response read outside return end");
  AST_OPT_B: assert property (O_OPT_PREF_B |-> !O_RERUN_B)
    else $error("optional and forced rerun together");

  COV_DONE: cover property (O_RET_DONE);
  COV_HALT: cover property ($rose(O_HALTED));
  COV_FMT: cover property (O_EXC_TAKE && O_EXC_CODE == 2'h3);
  COV_CP: cover property (O_CP_RESP_RD);
endmodule

bind bfr_frame_restore bfr_frame_restore_sva i_sva (.I_CLOCK, .I_SYS_RST, .I_WB_CYC,
  .I_WB_STB, .O_WB_ACK, .O_MEM_REQ, .O_MEM_ADDR, .I_MEM_ACK, .I_BUS_FAULT_INPUT,
  .I_DATA_FAULT, .I_PREF_REQ, .I_PREF_ADDR_ERR, .O_PREF_START, .O_EXC_TAKE, .O_EXC_CODE,
  .O_HALTED, .O_RET_DONE, .O_CP_RESP_RD, .O_RERUN_B, .O_OPT_PREF_B);

// [bfr_mem_model.sv]
`timescale 1ns/100ps
module bfr_mem_model (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_req,
  input  wire [31:0] i_addr,
  input  wire        i_slow,
  input  wire        i_flt_en,
  input  wire [31:0] i_flt_addr,
  output reg         o_ack = 1'b0,
  output reg         o_fault = 1'b0,
  output reg  [15:0] o_rdata = 16'h0000
);
  reg     [15:0] mem [0:255];
  reg     [1:0]  wait_reg = 2'h0;
  integer        k;

  initial
  begin
    for (k = 0; k < 256; k = k + 1)
      mem[k] = 16'h0000;
  end

  // Data line scrambles whenever no answer is given
  always @(posedge i_clk)
  begin
    o_ack <= 1'b0;
    o_fault <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_rst)
      wait_reg <= 2'h0;
    else if (i_req && !o_ack && !o_fault)
    begin
      if (i_slow && wait_reg != 2'h3)
        wait_reg <= wait_reg + 2'h1;
      else
      begin
        wait_reg <= 2'h0;
        if (i_flt_en && i_addr == i_flt_addr)
          o_fault <= 1'b1;
        else
        begin
          o_ack <= 1'b1;
          o_rdata <= mem[i_addr[8:1]];
        end
      end
    end
  end
endmodule

// [bfr_testbench.sv]
`timescale 1ns/100ps
`include "bfr_defs.vh"
module testbench;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         cyc = 1'b0;
  reg         stb = 1'b0;
  reg         we = 1'b0;
  reg  [5:0]  adr = 6'h00;
  reg  [31:0] dat = 32'h0;
  reg  [7:0]  dv = 8'h00;
  reg  [8:0]  pf = 9'h000;
  reg         slow = 1'b0;
  reg         fen = 1'b0;
  reg  [31:0] fadr = 32'h0;
  reg  [31:0] q;
  reg  [2:0]  res;
  reg         cps;
  integer     nx = 0;
  integer     k;
  integer     i;
  integer     fail_count = 0;
  integer     n_checks = 0;
  wire [31:0] rdat, maddr;
  wire [15:0] mdat;
  wire [1:0]  ecode;
  wire [2:0]  space;
  wire        ack, mreq, mack, bflt, pst, exc, halted, done, cprd, rb, rcc, ob, oc, rdf;

  bfr_frame_restore i_bfr_frame_restore (.I_CLOCK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(dat), .I_WB_SEL(4'hf),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_MEM_REQ(mreq), .O_MEM_ADDR(maddr),
    .I_MEM_ACK(mack), .I_MEM_RDATA(mdat), .I_BUS_FAULT_INPUT(bflt), .I_DATA_FAULT(dv[7]),
    .I_DATA_LOCKED(dv[6]), .I_DATA_READ(dv[5]), .I_DATA_SIZE(dv[4:3]),
    .I_DATA_SPACE(dv[2:0]), .I_PREF_ERR_B(pf[8]), .I_PREF_ERR_C(pf[7]),
    .I_PREF_FILL_B(pf[6]), .I_PREF_FILL_C(pf[5]), .I_USE_B(pf[4]), .I_USE_C(pf[3]),
    .I_PREF_REQ(pf[2]), .I_PREF_ADDR_ERR(pf[1]), .I_PIPE_BOTH(pf[0]),
    .O_PREF_START(pst), .O_EXC_TAKE(exc), .O_EXC_CODE(ecode), .O_HALTED(halted),
    .O_RET_DONE(done), .O_CP_RESP_RD(cprd), .O_RERUN_B(rb), .O_RERUN_C(rcc),
    .O_OPT_PREF_B(ob), .O_OPT_PREF_C(oc), .O_RERUN_DATA(rdf), .O_PREF_SPACE(space));

  bfr_mem_model i_bfr_mem_model (.i_clk(clk), .i_rst(rst), .i_req(mreq), .i_addr(maddr),
    .i_slow(slow), .i_flt_en(fen), .i_flt_addr(fadr), .o_ack(mack), .o_fault(bflt),
    .o_rdata(mdat));

  initial
  begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (exc === 1'b1)
      nx <= nx + 1;
  end

  task final_report;
    begin
      if (fail_count == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task wb(input w, input [3:0] idx, input [31:0] d);
    integer n;
    begin
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      dat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 20)
        fail_count = fail_count + 1;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
    end
  endtask

  task rc(input [3:0] idx, input [31:0] e);
    begin
      wb(1'b0, idx, 32'h0);
      chk($sformatf("reg %h", idx), e, q);
    end
  endtask

  task pp(input [7:0] d, input [8:0] p);
    begin
      dv <= d;
      pf <= p;
      @(posedge clk);
      dv <= 8'h00;
      pf <= 9'h000;
      repeat (2) @(posedge clk);
    end
  endtask

  task mw(input [31:0] a, input [15:0] v);
    begin
      i_bfr_mem_model.mem[a[8:1]] = v;
    end
  endtask

  task fr(input [31:0] b, input [15:0] f, input [15:0] s, input [15:0] pl, input [15:0] w);
    begin
      mw(b + `BFR_OFF_SR, s);
      mw(b + `BFR_OFF_PC_HI, 16'h0000);
      mw(b + `BFR_OFF_PC_LO, pl);
      mw(b + `BFR_OFF_FMT, f);
      mw(b + `BFR_OFF_FSW, w);
    end
  endtask

  // Result: 4 done, 7 halted, else exception code
  task run(input [31:0] sp, input [2:0] e);
    integer n;
    begin
      res = 3'h0;
      cps = 1'b0;
      n = 0;
      wb(1'b1, `BFR_IDX_SP, sp);
      wb(1'b1, `BFR_IDX_CTRL, 32'h1);
      while (res == 3'h0 && n < 400)
      begin
        @(posedge clk);
        n = n + 1;
        if (cprd === 1'b1)
          cps = 1'b1;
        if (done === 1'b1)
          res = 3'h4;
        else if (exc === 1'b1)
          res = {1'b0, ecode};
        else if (halted === 1'b1)
          res = 3'h7;
      end
      chk("result", {29'h0, e}, {29'h0, res});
    end
  endtask

  initial
  begin
    #1000000;
    fail_count = fail_count + 1;
    final_report;
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(`BFR_IDX_STATUS, 32'h0);
    rc(`BFR_IDX_FSW, {16'h0, `BFR_FSW_RESET});
    rc(4'hf, 32'h0);
    pp(8'hf5, 9'h000);
    rc(`BFR_IDX_FSW, 32'h01e5);
    k = nx;
    pp(8'h00, 9'h080);
    chk("exc count", k, nx);
    pp(8'h00, 9'h100);
    pp(8'h00, 9'h010);
    rc(`BFR_IDX_FSW, 32'h7000);
    pp(8'h00, 9'h060);
    for (i = 0; i < 2; i = i + 1)
    begin
      pp(8'h00, 9'h006 + i[8:0]);
      rc(`BFR_IDX_FSW, i ? 32'h3000 : 32'h2000);
    end
    wb(1'b1, `BFR_IDX_FSW, 32'hffff);
    rc(`BFR_IDX_FSW, 32'h3100);
    pp(8'h00, 9'h004);
    fr(32'h100, 16'ha000, 16'h2000, 16'h1000, 16'hf100);
    run(32'h100, 3'h4);
    rc(`BFR_IDX_SP, 32'h120);
    rc(`BFR_IDX_PC, 32'h1000);
    rc(`BFR_IDX_STAGE_B, 32'h1004);
    rc(`BFR_IDX_STAGE_C, 32'h1002);
    rc(`BFR_IDX_FSW, 32'hf100);
    chk("rerun", 32'h19, {27'h0, rb, rcc, ob, oc, rdf});
    chk("space", 32'h6, {29'h0, space});
    fr(32'h140, 16'hb000, 16'h0000, 16'h2000, 16'h2000);
    mw(32'h164, 16'h0000);
    mw(32'h166, 16'h3004);
    run(32'h140, 3'h4);
    rc(`BFR_IDX_SP, 32'h19c);
    rc(`BFR_IDX_STAGE_B, 32'h3004);
    rc(`BFR_IDX_STAGE_C, 32'h3002);
    chk("rerun", 32'h02, {27'h0, rb, rcc, ob, oc, rdf});
    chk("space", 32'h2, {29'h0, space});
    mw(32'h176, 16'h1000);
    run(32'h140, 3'h3);
    rc(`BFR_IDX_SP, 32'h140);
    rc(`BFR_IDX_FRAME_BASE, 32'h140);
    mw(32'h106, 16'h5000);
    run(32'h100, 3'h3);
    mw(32'h106, 16'ha000);
    fadr <= 32'h11e;
    fen <= 1'b1;
    run(32'h100, 3'h1);
    rc(`BFR_IDX_SP, 32'h100);
    fen <= 1'b0;
    slow <= 1'b1;
    mw(32'h106, 16'h9000);
    run(32'h100, 3'h4);
    rc(`BFR_IDX_SP, 32'h114);
    chk("resp read", 32'h1, {31'h0, cps});
    slow <= 1'b0;
    mw(32'h106, 16'ha000);
    fadr <= 32'h10a;
    fen <= 1'b1;
    run(32'h100, 3'h7);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(`BFR_IDX_STATUS, 32'h0);
    final_report;
  end
endmodule
